// *** src/acc_top.sv ***
// analog comparator control with apb register slave
//
// Operation
// RL1: unity polarity: high when positive exceeds negative
// RL2: output_invert bit 4 inverts reported result
// RL3: eight modes chosen by mode_select
// RL4: pin_direction sets each pin's direction
// RL5: result unreliable while settling after mode change
// RL6: software masks interrupts during mode change
// RL7: comparator_result readable, read only
// RL8: three modes drive result onto output_pin_two
// RL9: direction bit 2 enables output_pin_two driver
// RL10: analog input pins read zero
// RL11: reference feeds comparator in four modes
// RL12: 32 levels, 16 per range
// RL13: range 1 low ladder, 0 high ladder
// RL14: comparator and reference keep running asleep
// RL15: mode 111 off, reference_power clear off
// RL16: change event while asleep wakes device
// RL17: wake leaves control registers untouched
// RL18: reset gives mode 000, reference off
// RL19: reset mode: analog pins, all disabled
// RL20: software waits settling delays before use
// RL21: change sets flag; write zero clears, one sets
// RL22: mismatch re-sets flag until control accessed
// RL23: raw result synchronised before use; output_pin_two is driven from the unsynchronised raw result
//
// Chosen here: the APB interface to the registers.
`default_nettype none
module acc_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [acc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [acc_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [acc_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// analog front end
	input wire logic cmp_raw_i,
	output acc_pkg::acc_analog_t analog_o,
	// port pins
	input wire logic [5:0] pins_i,
	output logic [5:0] pins_o,
	output logic [5:0] pins_oe_o,
	// core power state
	input wire logic sleep_i,
	output logic wake_o
);

	// ==========================================================
	// reset release
	logic rst_s1;
	logic rst_n;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// ==========================================================
	// control state
	acc_pkg::acc_cmp_ctrl_t cmp_ctrl;
	acc_pkg::acc_ref_ctrl_t ref_ctrl;
	logic [5:0] port_latch;
	logic change_flag;
	logic last_read;
	logic [acc_pkg::SETTLE_W-1:0] settle_cnt;

	// ==========================================================
	// apb decode
	logic setup_ph;
	logic access_done;
	logic wr_en;
	logic hit_cmp;
	logic hit_ref;
	logic hit_dir;
	logic hit_flags;
	logic hit_port;
	logic hit_stat;
	logic mapped;
	logic [7:0] wbyte;

	assign setup_ph = psel_i && !penable_i;
	assign access_done = psel_i && penable_i && pready_o;
	assign wr_en = access_done && pwrite_i && pstrb_i[0] && !pslverr_o;
	assign wbyte = pwdata_i[7:0];
	assign hit_cmp = (paddr_i == acc_pkg::ADDR_CMP_CTRL);
	assign hit_ref = (paddr_i == acc_pkg::ADDR_REF_CTRL);
	assign hit_dir = (paddr_i == acc_pkg::ADDR_PIN_DIR);
	assign hit_flags = (paddr_i == acc_pkg::ADDR_PERIPH_FLAGS);
	assign hit_port = (paddr_i == acc_pkg::ADDR_PORT_PINS);
	assign hit_stat = (paddr_i == acc_pkg::ADDR_CMP_STATUS);
	assign mapped = hit_cmp | hit_ref | hit_dir | hit_flags | hit_port | hit_stat;

	// ==========================================================
	// comparator result synchroniser
	logic cmp_s1;
	logic cmp_s2;
	logic cmp_s3;
	logic cmp_sync;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
			cmp_s3 <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_s1 <= cmp_raw_i; // RL23
			cmp_s2 <= cmp_s1;
			cmp_s3 <= cmp_s2;
			if (cmp_s2 == cmp_s3) begin
				cmp_sync <= cmp_s3; // RL23
			end
		end
	end

	// ==========================================================
	// pin input synchronisers
	logic [5:0] pin_s1;
	logic [5:0] pin_s2;
	logic [5:0] pin_s3;
	logic [5:0] pin_sync;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_pin_sync
			always_ff @(posedge mclk_i or negedge rst_n) begin
				if (!rst_n) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pins_i[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi]) begin
						pin_sync[gi] <= pin_s3[gi];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// mode decode
	logic mode_on;
	logic mode_uses_ref;
	logic mode_has_out;
	logic [5:0] analog_mask;

	always_comb begin
		mode_on = 1'b1;
		mode_uses_ref = 1'b0;
		mode_has_out = 1'b0;
		analog_mask = 6'h03;
		case (cmp_ctrl.mode_select) // RL3
			acc_pkg::MODE_RESET: begin
				mode_on = 1'b0; // RL19
			end
			acc_pkg::MODE_PIN_OUT: begin
				mode_has_out = 1'b1; // RL8
			end
			acc_pkg::MODE_PIN: begin
				mode_has_out = 1'b0;
			end
			acc_pkg::MODE_REF_OUT: begin
				mode_uses_ref = 1'b1; // RL11
				mode_has_out = 1'b1; // RL8
				analog_mask = 6'h02;
			end
			acc_pkg::MODE_REF: begin
				mode_uses_ref = 1'b1; // RL11
				analog_mask = 6'h02;
			end
			acc_pkg::MODE_MUX_REF_OUT: begin
				mode_uses_ref = 1'b1; // RL11
				mode_has_out = 1'b1; // RL8
			end
			acc_pkg::MODE_MUX_REF: begin
				mode_uses_ref = 1'b1; // RL11
			end
			acc_pkg::MODE_OFF: begin
				mode_on = 1'b0; // RL15
				analog_mask = 6'h00;
			end
			default: begin
				mode_on = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// reported result
	logic result_now;
	logic result_q;
	logic mismatch;
	logic settling;

	// high when positive input exceeds negative, optionally inverted
	assign result_now = mode_on && (cmp_sync ^ cmp_ctrl.output_invert); // RL1 RL2
	assign mismatch = (result_now != last_read); // RL22
	assign settling = (settle_cnt != '0); // RL5

	// ==========================================================
	// apb response
	logic [7:0] next_rbyte;

	always_comb begin
		next_rbyte = 8'h00;
		if (hit_cmp) begin
			next_rbyte[acc_pkg::CMP_RESULT_BIT] = result_now; // RL7
			next_rbyte[acc_pkg::CMP_INVERT_BIT] = cmp_ctrl.output_invert;
			next_rbyte[acc_pkg::CMP_SWAP_BIT] = cmp_ctrl.input_swap;
			next_rbyte[2:0] = cmp_ctrl.mode_select;
		end else if (hit_ref) begin
			next_rbyte[acc_pkg::REF_POWER_BIT] = ref_ctrl.reference_power;
			next_rbyte[acc_pkg::REF_RANGE_BIT] = ref_ctrl.reference_range;
			next_rbyte[3:0] = ref_ctrl.reference_level;
		end else if (hit_dir) begin
			next_rbyte[5:0] = ~pins_oe_o; // RL4
		end else if (hit_flags) begin
			next_rbyte[acc_pkg::FLAG_CHANGE_BIT] = change_flag;
		end else if (hit_port) begin
			next_rbyte[5:0] = pin_sync & ~analog_mask; // RL10
		end else if (hit_stat) begin
			next_rbyte[acc_pkg::STAT_VALID_BIT] = !settling;
			next_rbyte[acc_pkg::STAT_MISMATCH_BIT] = mismatch;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= setup_ph;
			if (setup_ph) begin
				prdata_o <= {24'h00_0000, next_rbyte};
				pslverr_o <= !mapped;
			end
		end
	end

	// ==========================================================
	// comparator_control, untouched by sleep or wake
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmp_ctrl <= acc_pkg::CMP_CTRL_RST; // RL18
		end else if (wr_en && hit_cmp) begin
			// result bit is not stored, writes cannot alter it
			cmp_ctrl.output_invert <= wbyte[acc_pkg::CMP_INVERT_BIT]; // RL2 RL7 RL17
			cmp_ctrl.input_swap <= wbyte[acc_pkg::CMP_SWAP_BIT];
			cmp_ctrl.mode_select <= wbyte[2:0]; // RL3
		end
	end

	// ==========================================================
	// reference_control
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			ref_ctrl <= acc_pkg::REF_CTRL_RST; // RL18
		end else if (wr_en && hit_ref) begin
			ref_ctrl.reference_power <= wbyte[acc_pkg::REF_POWER_BIT]; // RL15 RL17
			ref_ctrl.reference_range <= wbyte[acc_pkg::REF_RANGE_BIT]; // RL13
			ref_ctrl.reference_level <= wbyte[3:0]; // RL12
		end
	end

	// ==========================================================
	// pin direction and port latch
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			pins_oe_o <= ~acc_pkg::PIN_DIR_RST;
		end else if (wr_en && hit_dir) begin
			// cleared direction bit drives the pin
			pins_oe_o <= ~wbyte[5:0]; // RL4 RL9
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			port_latch <= acc_pkg::PORT_LATCH_RST;
		end else if (wr_en && hit_port) begin
			port_latch <= wbyte[5:0];
		end
	end

	// ==========================================================
	// pin outputs
	logic has_out_q;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			has_out_q <= 1'b0;
		end else begin
			has_out_q <= mode_has_out;
		end
	end

	// output_pin_two carries the raw result, unsynchronised
	always_comb begin
		pins_o = port_latch;
		if (has_out_q) begin
			pins_o[acc_pkg::PIN_CMP_OUT] = cmp_raw_i ^ cmp_ctrl.output_invert; // RL8
		end
	end

	// ==========================================================
	// analog front end controls, independent of sleep
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			analog_o <= '0; // RL19
		end else begin
			analog_o.cmp_enable <= mode_on; // RL14 RL15
			analog_o.use_reference <= mode_uses_ref; // RL11
			analog_o.input_swap <= cmp_ctrl.input_swap;
			analog_o.ref_enable <= ref_ctrl.reference_power; // RL14 RL15
			analog_o.ref_range <= ref_ctrl.reference_range; // RL13
			analog_o.ref_level <= ref_ctrl.reference_level; // RL12
		end
	end

	// ==========================================================
	// settling window after mode or reference change
	logic settle_start;

	assign settle_start = wr_en && ((hit_cmp && wbyte[2:0] != cmp_ctrl.mode_select) || hit_ref);

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			settle_cnt <= '0;
		end else if (settle_start) begin
			settle_cnt <= acc_pkg::SETTLE_W'(acc_pkg::SETTLE_CYCLES); // RL5
		end else if (settling) begin
			settle_cnt <= settle_cnt - 1'b1;
		end
	end

	// ==========================================================
	// last-read result and change flag
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			last_read <= 1'b0;
		end else if (access_done && hit_cmp) begin
			last_read <= prdata_o[acc_pkg::CMP_RESULT_BIT]; // RL22
		end
	end

	logic flag_set;

	// spurious changes while settling are not flagged
	assign flag_set = mismatch && !settling; // RL21 RL22 RL6

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			change_flag <= 1'b0;
		end else if (wr_en && hit_flags) begin
			change_flag <= wbyte[acc_pkg::FLAG_CHANGE_BIT] | flag_set; // RL21
		end else if (flag_set) begin
			change_flag <= 1'b1; // RL22
		end
	end

	// ==========================================================
	// wake on change while asleep
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= 1'b0;
			wake_o <= 1'b0;
		end else begin
			result_q <= result_now;
			wake_o <= sleep_i && mode_on && !settling && (result_now != result_q); // RL16
		end
	end

endmodule // acc_top
`default_nettype wire

// *** src/acc_pkg.sv ***
// constants and types for the analog comparator control block
`default_nettype none
package acc_pkg;

	// ==========================================================
	// bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
	localparam logic [7:0] IDX_CMP_CTRL = 8'h19;
	localparam logic [7:0] IDX_PIN_DIR = 8'h85;
	localparam logic [7:0] IDX_REF_CTRL = 8'h99;
	localparam logic [7:0] IDX_PORT_PINS = 8'h20;
	localparam logic [7:0] IDX_CMP_STATUS = 8'h21;
	localparam logic [11:0] ADDR_PERIPH_FLAGS = {2'b00, IDX_PERIPH_FLAGS, 2'b00};
	localparam logic [11:0] ADDR_CMP_CTRL = {2'b00, IDX_CMP_CTRL, 2'b00};
	localparam logic [11:0] ADDR_PIN_DIR = {2'b00, IDX_PIN_DIR, 2'b00};
	localparam logic [11:0] ADDR_REF_CTRL = {2'b00, IDX_REF_CTRL, 2'b00};
	localparam logic [11:0] ADDR_PORT_PINS = {2'b00, IDX_PORT_PINS, 2'b00};
	localparam logic [11:0] ADDR_CMP_STATUS = {2'b00, IDX_CMP_STATUS, 2'b00};

	// ==========================================================
	// field positions
	localparam int unsigned CMP_RESULT_BIT = 6;
	localparam int unsigned CMP_INVERT_BIT = 4;
	localparam int unsigned CMP_SWAP_BIT = 3;
	localparam int unsigned REF_POWER_BIT = 7;
	localparam int unsigned REF_RANGE_BIT = 5;
	localparam int unsigned FLAG_CHANGE_BIT = 3;
	localparam int unsigned STAT_VALID_BIT = 0;
	localparam int unsigned STAT_MISMATCH_BIT = 1;
	localparam int unsigned PIN_CMP_OUT = 2;

	// ==========================================================
	// reset values
	localparam logic [4:0] CMP_CTRL_RST = 5'h00;
	localparam logic [5:0] REF_CTRL_RST = 6'h00;
	localparam logic [5:0] PIN_DIR_RST = 6'h3f;
	localparam logic [5:0] PORT_LATCH_RST = 6'h00;

	// ==========================================================
	// mode_select encodings
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] MODE_PIN_OUT = 3'h1;
	localparam logic [2:0] MODE_PIN = 3'h2;
	localparam logic [2:0] MODE_REF_OUT = 3'h3;
	localparam logic [2:0] MODE_REF = 3'h4;
	localparam logic [2:0] MODE_MUX_REF_OUT = 3'h5;
	localparam logic [2:0] MODE_MUX_REF = 3'h6;
	localparam logic [2:0] MODE_OFF = 3'h7;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned SETTLE_TIME_NS = 10000;
	localparam int unsigned SETTLE_CYCLES =
		(SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SETTLE_W = 12;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic output_invert;
		logic input_swap;
		logic [2:0] mode_select;
	} acc_cmp_ctrl_t;

	typedef struct packed {
		logic reference_power;
		logic reference_range;
		logic [3:0] reference_level;
	} acc_ref_ctrl_t;

	typedef struct packed {
		logic cmp_enable;
		logic use_reference;
		logic input_swap;
		logic ref_enable;
		logic ref_range;
		logic [3:0] ref_level;
	} acc_analog_t;

endpackage
`default_nettype wire

// *** tb/acc_monitor.sv ***
// assertion checker bound to the comparator control top
`default_nettype none
module acc_monitor (
	// clock, reset and apb
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [acc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [acc_pkg::DATA_W-1:0] prdata_o,
	input wire logic pready_o,
	// front end, pins and power
	input wire logic cmp_raw_i,
	input wire acc_pkg::acc_analog_t analog_o,
	input wire logic [5:0] pins_o,
	input wire logic [5:0] pins_oe_o,
	input wire logic sleep_i,
	input wire logic wake_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// helpers
	logic wr_done;
	logic dir_wr;
	logic ctl_wr;
	assign wr_done = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
	assign dir_wr = wr_done && paddr_i == acc_pkg::ADDR_PIN_DIR;
	assign ctl_wr = wr_done && (paddr_i == acc_pkg::ADDR_CMP_CTRL ||
		paddr_i == acc_pkg::ADDR_REF_CTRL);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	// ==========================================================
	// assertions
	AST_PREADY_ONE: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("pready not one cycle after setup");
	AST_RDATA_UPPER: assert property (pready_o |-> prdata_o[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	AST_OE_BY_WRITE: assert property ($changed(pins_oe_o) |-> $past(dir_wr) || $past(dir_wr, 2))
		else $error("output enables moved without direction write");
	AST_CTRL_BY_WRITE: assert property ($changed(analog_o) |-> $past(ctl_wr) || $past(ctl_wr, 2))
		else $error("analog controls moved without control write");
	AST_PIN2_RAW: assert property ($changed(pins_o[2]) && !$past(psel_i) && !$past(psel_i, 2)
		&& !$past(psel_i, 3) |-> $changed(cmp_raw_i))
		else $error("pin two moved without raw result change");
	AST_RESET_STATE: assert property ($rose(resetn_i) |-> analog_o == '0 && pins_oe_o == 6'h00
		&& !wake_o)
		else $error("outputs not in reset state");
	AST_WAKE_ASLEEP: assert property (wake_o |-> ($past(sleep_i) || $past(sleep_i, 2))
		&& analog_o.cmp_enable)
		else $error("wake while awake or comparator off");
	AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
		else $error("wake longer than one cycle");
	// ==========================================================
	// covers
	COV_WAKE: cover property (wake_o);
	COV_PIN2: cover property (pins_oe_o[2] && pins_o[2]);
	COV_REF: cover property (analog_o.use_reference && analog_o.ref_enable);
endmodule // acc_monitor
bind acc_top acc_monitor u_mon (.mclk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pstrb_i, .prdata_o, .pready_o, .cmp_raw_i, .analog_o, .pins_o, .pins_oe_o, .sleep_i,
	.wake_o);
`default_nettype wire

// *** tb/acc_front_model.sv ***
// behavioural comparator and reference ladder front end
`default_nettype none
module acc_front_model #(
	parameter int VDD_MV = 3000
) (
	// clock and controls
	input wire logic mclk_i,
	input wire acc_pkg::acc_analog_t analog_i,
	// pin voltages in millivolts
	input wire logic [15:0] pos_mv_i,
	input wire logic [15:0] neg_mv_i,
	// raw result
	output logic cmp_raw_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int ref_mv;
	int plus_mv;
	logic valid;
	logic junk = 1'b0;
	// no valid drive when unpowered: changing pattern
	always @(posedge mclk_i) begin
		junk <= !junk;
	end
	always_comb begin
		if (analog_i.ref_range) begin
			ref_mv = analog_i.ref_level * VDD_MV / 24;
		end else begin
			ref_mv = VDD_MV / 4 + analog_i.ref_level * VDD_MV / 32;
		end
		plus_mv = analog_i.use_reference ? ref_mv : int'(pos_mv_i);
		valid = analog_i.cmp_enable && (analog_i.ref_enable || !analog_i.use_reference);
		cmp_raw_o = valid ? (plus_mv > int'(neg_mv_i)) : junk;
	end
endmodule // acc_front_model
`default_nettype wire

// *** tb/test_analog_comparator_control.sv ***
// self-checking bench for the comparator control block
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_analog_comparator_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 20000;
	localparam logic [11:0] A_CMP = acc_pkg::ADDR_CMP_CTRL;
	localparam logic [11:0] A_REF = acc_pkg::ADDR_REF_CTRL;
	localparam logic [11:0] A_DIR = acc_pkg::ADDR_PIN_DIR;
	localparam logic [11:0] A_FLG = acc_pkg::ADDR_PERIPH_FLAGS;
	localparam logic [11:0] A_PRT = acc_pkg::ADDR_PORT_PINS;
	localparam logic [11:0] A_STA = acc_pkg::ADDR_CMP_STATUS;
	typedef struct packed {
		logic [7:0] cmp;
		logic [7:0] rfc;
		logic [15:0] pos;
		logic [15:0] neg;
		logic [7:0] exp;
	} acc_row_t;
	localparam acc_row_t ROWS [9] = '{
		'{8'h02, 8'h00, 16'h07d0, 16'h03e8, 8'h42}, '{8'h02, 8'h00, 16'h03e8, 16'h07d0, 8'h02},
		'{8'h12, 8'h00, 16'h07d0, 16'h03e8, 8'h12}, '{8'h12, 8'h00, 16'h03e8, 16'h07d0, 8'h52},
		'{8'h04, 8'hac, 16'h0000, 16'h0578, 8'h44}, '{8'h04, 8'hac, 16'h0000, 16'h0640, 8'h04},
		'{8'h04, 8'h88, 16'h0000, 16'h0578, 8'h44}, '{8'h04, 8'h8f, 16'h0000, 16'h0834, 8'h44},
		'{8'h07, 8'h00, 16'h07d0, 16'h03e8, 8'h07}};
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic sleep = 1'b0;
	logic [15:0] pos_mv = 16'h0000;
	logic [15:0] neg_mv = 16'h0000;
	logic [5:0] ext = 6'h3f;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cmp_raw;
	acc_pkg::acc_analog_t analog;
	logic [5:0] pins_out;
	logic [5:0] pins_oe;
	logic [5:0] pins_in;
	logic wake;
	logic [31:0] q;
	logic err;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	int wakes = 0;
	assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext);
	acc_top uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cmp_raw_i(cmp_raw),
		.analog_o(analog), .pins_i(pins_in), .pins_o(pins_out), .pins_oe_o(pins_oe),
		.sleep_i(sleep), .wake_o(wake));
	acc_front_model front (.mclk_i(mclk_i), .analog_i(analog), .pos_mv_i(pos_mv),
		.neg_mv_i(neg_mv), .cmp_raw_o(cmp_raw));
	// ==========================================================
	// clock, timeout and helpers
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (wake === 1'b1) begin
			wakes++;
		end
		if (cycles == LIMIT) begin
			err_total++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge mclk_i);
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge mclk_i);
		penable <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] ex, input string nm);
		apb(a, 1'b0, 8'h00);
		`CHK(nm, {24'h00_0000, ex}, q)
	endtask
	task automatic chk_reset();
		`CHK("analog_o", 9'h000, analog)
		`CHK("pins_oe_o", 6'h00, pins_oe)
		rd(A_CMP, 8'h00, "cmp_ctrl");
		rd(A_REF, 8'h00, "ref_ctrl");
		rd(A_DIR, 8'h3f, "pin_dir");
		rd(A_FLG, 8'h00, "flags");
		rd(A_PRT, 8'h3c, "port_pins");
		$display("test reset done");
	endtask
	// ==========================================================
	// main sequence
	initial begin
		tick(20);
		resetn_i <= 1'b1;
		tick(3);
		chk_reset();
		apb(A_CMP, 1'b1, 8'hff);
		rd(A_CMP, 8'h1f, "cmp_ctrl read only");
		pstrb <= 4'h0;
		apb(A_CMP, 1'b1, 8'h02);
		pstrb <= 4'hf;
		rd(A_CMP, 8'h1f, "cmp_ctrl strobe");
		apb(A_REF, 1'b1, 8'hff);
		rd(A_REF, 8'haf, "ref_ctrl bits");
		apb(A_DIR, 1'b1, 8'hff);
		rd(A_DIR, 8'h3f, "pin_dir bits");
		rd(12'h100, 8'h00, "unmapped");
		`CHK("unmapped err", 1'b1, err)
		$display("test registers done");
		apb(A_DIR, 1'b1, 8'h3b);
		for (int i = 0; i < 9; i++) begin
			apb(A_REF, 1'b1, ROWS[i].rfc);
			apb(A_CMP, 1'b1, ROWS[i].cmp);
			pos_mv <= ROWS[i].pos;
			neg_mv <= ROWS[i].neg;
			tick(8);
			rd(A_CMP, ROWS[i].exp, "result row");
		end
		$display("test result table done");
		apb(A_REF, 1'b1, 8'hac);
		pos_mv <= 16'h07d0;
		neg_mv <= 16'h03e8;
		for (int m = 0; m < 8; m++) begin
			apb(A_CMP, 1'b1, 8'(m));
			tick(8);
			`CHK("cmp_enable", (m != 0 && m != 7), analog.cmp_enable)
			`CHK("use_reference", (m >= 3 && m <= 6), analog.use_reference)
			`CHK("pin two", (m == 1 || m == 3 || m == 5), pins_out[2])
			apb(A_PRT, 1'b0, 8'h00);
			`CHK("analog bits", (m == 7) ? 2'b11 : (m == 3 || m == 4) ? 2'b01 : 2'b00, q[1:0])
		end
		apb(A_CMP, 1'b1, 8'h01);
		apb(A_DIR, 1'b1, 8'h3f);
		tick(2);
		`CHK("oe tristate", 6'h00, pins_oe)
		apb(A_DIR, 1'b1, 8'h3b);
		tick(2);
		`CHK("oe drive", 6'h04, pins_oe)
		$display("test modes done");
		neg_mv <= 16'h0fa0;
		tick(10);
		rd(A_FLG, 8'h00, "flag settling");
		rd(A_STA, 8'h00, "status settling");
		tick(acc_pkg::SETTLE_CYCLES);
		rd(A_STA, 8'h01, "status settled");
		rd(A_CMP, 8'h01, "result low");
		apb(A_FLG, 1'b1, 8'h00);
		rd(A_FLG, 8'h00, "flag clear");
		neg_mv <= 16'h03e8;
		tick(10);
		rd(A_FLG, 8'h08, "flag change");
		apb(A_FLG, 1'b1, 8'h00);
		rd(A_FLG, 8'h08, "flag mismatch");
		rd(A_STA, 8'h03, "status mismatch");
		rd(A_CMP, 8'h41, "result high");
		apb(A_FLG, 1'b1, 8'h00);
		rd(A_FLG, 8'h00, "flag ended");
		apb(A_FLG, 1'b1, 8'h08);
		rd(A_FLG, 8'h08, "flag by write");
		apb(A_FLG, 1'b1, 8'h00);
		$display("test flag done");
		sleep <= 1'b1;
		neg_mv <= 16'h0fa0;
		wakes = 0;
		tick(20);
		`CHK("wake pulses", 1, wakes)
		`CHK("cmp asleep", 1'b1, analog.cmp_enable)
		sleep <= 1'b0;
		rd(A_CMP, 8'h01, "cmp_ctrl wake");
		rd(A_REF, 8'hac, "ref_ctrl wake");
		$display("test sleep done");
		resetn_i <= 1'b0;
		tick(3);
		resetn_i <= 1'b1;
		tick(3);
		chk_reset();
		finish_test();
	end
endmodule // test_analog_comparator_control
`default_nettype wire
